// ==== hw/spt_port_params.v ====
// How it works
// - Page identifier reads back as 19h.
// - Subpage-format flag reads zero; writes with it set are refused.
// - Page length reads 06h, bytes after the length byte.
// - Protocol code field reads 6h for SSP.
// - Indicator meaning bit is one copy shared by all ports.
// - Scope policy is shared or per port; per port by default here.
// - Per-port values steer that port; shared values steer all ports.
// - A write to one port's values leaves other ports unchanged.
// - Retry rejected connections for the nexus-loss time, then report loss.
// - Code 0000h uses vendor time; 0001h-FFFEh are milliseconds.
// - Code FFFFh retries forever and never reports loss.
// - Without the page a vendor nexus-loss time applies.
// - Default nexus-loss value is nonzero, 2000 ms.
// - Missing expected frame within timeout aborts the command.
// - Response timeout of zero disables the timer.
// - Without the page no response timer exists.
// - Long subpage codes decode to not allowed, phy, shared, vendor, all.
// - Page present for every logical unit using mode commands.
`include "spt_consts.vh"
`default_nettype none
module spt_port_params #(
  parameter NPORT = 2, // SSP target ports
  parameter PAGE_PRESENT = 1, // Page implemented
  parameter [15:0] VENDOR_NXL_MS = 16'h07D0 // Vendor nexus time
) (
  input wire clk, // 40 MHz clock
  input wire rst, // Sync reset, active high
  input wire pageWr, // Mode select byte write strobe
  input wire pageRd, // Mode sense byte read strobe
  input wire [2:0] pageAddr, // Byte offset in page
  input wire [7:0] pageWrData, // Write byte
  input wire [0:0] portSel, // Addressed target port
  input wire sharedPolicy, // Scope policy: 1 shared, 0 per port
  input wire [7:0] subpageCode, // Long subpage code to classify
  input wire [NPORT-1:0] connRejected, // Connection rejected, retrying
  input wire [NPORT-1:0] connAccepted, // Connection established
  input wire [NPORT-1:0] frameExpect, // Expected frame outstanding
  input wire [NPORT-1:0] frameRcvd, // Expected frame arrived
  output reg [7:0] pageRdData, // Read byte
  output reg pageRdValid, // Read data valid pulse
  output reg pageWrErr, // Write refused pulse
  output reg [2:0] subpageClass, // 0 rsvd,1 bad,2 phy,3 shr,4 vnd,5 all
  output reg indicatorMeaning, // Shared indicator meaning bit
  output reg [NPORT-1:0] nexusLoss, // Nexus loss pulse per port
  output reg [NPORT-1:0] cmdAbort // Command abort pulse per port
);
  localparam [15:0] TICK_CYC = `SPT_TICK_CYC;

  reg [15:0] tickCnt_q;
  reg msTick_q;
  reg [NPORT-1:0] psFlag_q;
  reg [15:0] nxl_q [0:NPORT-1];
  reg [15:0] rsp_q [0:NPORT-1];
  reg [15:0] nxlSh_q;
  reg [15:0] rspSh_q;
  reg indicator_q;
  reg [NPORT-1:0] retrying_q;
  reg [NPORT-1:0] waiting_q;

  // Millisecond tick
  always @(posedge clk) begin
    if (rst) begin
      tickCnt_q <= 16'h0000;
      msTick_q <= 1'b0;
    end else if (tickCnt_q == TICK_CYC - 16'h0001) begin
      tickCnt_q <= 16'h0000;
      msTick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
      msTick_q <= 1'b0;
    end
  end

  // Page writes
  wire spfSet = pageWrData[`SPT_BIT_SPF];
  integer i;
  always @(posedge clk) begin
    pageWrErr <= 1'b0;
    if (rst) begin
      indicator_q <= 1'b0;
      nxlSh_q <= `SPT_NXL_RESET;
      rspSh_q <= `SPT_RSP_RESET;
      psFlag_q <= {NPORT{1'b0}};
      for (i = 0; i < NPORT; i = i + 1) begin
        nxl_q[i] <= `SPT_NXL_RESET;
        rsp_q[i] <= `SPT_RSP_RESET;
      end
    end else if (pageWr) begin
      case (pageAddr)
        `SPT_OFF_HDR: begin
          if (spfSet != `SPT_SPF_SHORT)
            pageWrErr <= 1'b1;
          else
            psFlag_q[portSel] <= pageWrData[`SPT_BIT_PS];
        end
        `SPT_OFF_IND: indicator_q <= pageWrData[`SPT_BIT_IND];
        `SPT_OFF_NXL_HI: begin
          if (sharedPolicy) nxlSh_q[15:8] <= pageWrData;
          else nxl_q[portSel][15:8] <= pageWrData;
        end
        `SPT_OFF_NXL_LO: begin
          if (sharedPolicy) nxlSh_q[7:0] <= pageWrData;
          else nxl_q[portSel][7:0] <= pageWrData;
        end
        `SPT_OFF_RSP_HI: begin
          if (sharedPolicy) rspSh_q[15:8] <= pageWrData;
          else rsp_q[portSel][15:8] <= pageWrData;
        end
        `SPT_OFF_RSP_LO: begin
          if (sharedPolicy) rspSh_q[7:0] <= pageWrData;
          else rsp_q[portSel][7:0] <= pageWrData;
        end
        default: pageWrErr <= 1'b0;
      endcase
    end
  end

  // Effective values per port
  wire [15:0] selNxl = sharedPolicy ? nxlSh_q : nxl_q[portSel];
  wire [15:0] selRsp = sharedPolicy ? rspSh_q : rsp_q[portSel];

  // Page reads
  always @(posedge clk) begin
    if (rst) begin
      pageRdData <= 8'h00;
      pageRdValid <= 1'b0;
    end else begin
      pageRdValid <= pageRd;
      if (pageRd) begin
        case (pageAddr)
          `SPT_OFF_HDR: pageRdData <= {psFlag_q[portSel],
            `SPT_SPF_SHORT, `SPT_PAGE_CODE};
          `SPT_OFF_LEN: pageRdData <= `SPT_PAGE_LEN;
          `SPT_OFF_IND: pageRdData <= {3'h0, indicator_q,
            `SPT_PROTO_CODE};
          `SPT_OFF_NXL_HI: pageRdData <= selNxl[15:8];
          `SPT_OFF_NXL_LO: pageRdData <= selNxl[7:0];
          `SPT_OFF_RSP_HI: pageRdData <= selRsp[15:8];
          `SPT_OFF_RSP_LO: pageRdData <= selRsp[7:0];
          default: pageRdData <= 8'h00;
        endcase
      end
    end
  end

  // Subpage classification
  always @(posedge clk) begin
    if (rst) begin
      subpageClass <= 3'h0;
    end else if (subpageCode == `SPT_SUB_NONE) begin
      subpageClass <= 3'h1;
    end else if (subpageCode == `SPT_SUB_PHY) begin
      subpageClass <= 3'h2;
    end else if (subpageCode == `SPT_SUB_SHARED) begin
      subpageClass <= 3'h3;
    end else if (subpageCode >= `SPT_SUB_VEND_LO &&
                 subpageCode <= `SPT_SUB_VEND_HI) begin
      subpageClass <= 3'h4;
    end else if (subpageCode == `SPT_SUB_ALL) begin
      subpageClass <= 3'h5;
    end else begin
      subpageClass <= 3'h0;
    end
  end

  always @(posedge clk) begin
    if (rst) indicatorMeaning <= 1'b0;
    else indicatorMeaning <= indicator_q;
  end

  // Per-port timers
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : gPort
      wire [15:0] nxlCode = sharedPolicy ? nxlSh_q : nxl_q[g];
      wire [15:0] rspCode = sharedPolicy ? rspSh_q : rsp_q[g];
      wire [15:0] nxlLoad = (PAGE_PRESENT == 0 ||
        nxlCode == `SPT_NXL_VENDOR) ? VENDOR_NXL_MS : nxlCode;
      wire retryAlways = (PAGE_PRESENT != 0) &&
        (nxlCode == `SPT_NXL_FOREVER);
      wire [15:0] rspLoad = (PAGE_PRESENT != 0) ? rspCode
        : 16'h0000;
      wire nxlStart = connRejected[g] && !retrying_q[g];
      wire rspStart = (frameExpect[g] && !waiting_q[g]) ||
        (frameRcvd[g] && frameExpect[g]);
      wire nxlExp;
      wire rspExp;
      wire nxlRun;
      wire rspRun;
      always @(posedge clk) begin
        if (rst) begin
          retrying_q[g] <= 1'b0;
          waiting_q[g] <= 1'b0;
          nexusLoss[g] <= 1'b0;
          cmdAbort[g] <= 1'b0;
        end else begin
          // Retry window closes once rejections stop, so no stale expiry
          if (connAccepted[g] || nxlExp || !connRejected[g])
            retrying_q[g] <= 1'b0;
          else if (connRejected[g]) retrying_q[g] <= 1'b1;
          waiting_q[g] <= frameExpect[g] && !rspExp;
          nexusLoss[g] <= nxlExp && !retryAlways;
          cmdAbort[g] <= rspExp;
        end
      end
      spt_ms_timer uNxl (
        .clk(clk),
        .rst(rst),
        .tick(msTick_q),
        .start(nxlStart),
        .stop(connAccepted[g] || retryAlways || !connRejected[g]),
        .loadVal(nxlLoad),
        .running(nxlRun),
        .expired(nxlExp)
      );
      spt_ms_timer uRsp (
        .clk(clk),
        .rst(rst),
        .tick(msTick_q),
        .start(rspStart),
        .stop(!frameExpect[g]),
        .loadVal(rspLoad),
        .running(rspRun),
        .expired(rspExp)
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hw/spt_consts.vh ====
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH
// Page byte offsets
`define SPT_OFF_HDR 3'h0
`define SPT_OFF_LEN 3'h1
`define SPT_OFF_IND 3'h2
`define SPT_OFF_RSV 3'h3
`define SPT_OFF_NXL_HI 3'h4
`define SPT_OFF_NXL_LO 3'h5
`define SPT_OFF_RSP_HI 3'h6
`define SPT_OFF_RSP_LO 3'h7
// Fixed header values
`define SPT_PAGE_CODE 6'h19
`define SPT_PAGE_LEN 8'h06
`define SPT_PROTO_CODE 4'h6
`define SPT_SPF_SHORT 1'b0
// Field positions
`define SPT_BIT_PS 7
`define SPT_BIT_SPF 6
`define SPT_BIT_IND 4
// Nexus-loss codes
`define SPT_NXL_VENDOR 16'h0000
`define SPT_NXL_FOREVER 16'hFFFF
`define SPT_NXL_RESET 16'h07D0
`define SPT_RSP_RESET 16'h0000
// Subpage codes
`define SPT_SUB_NONE 8'h00
`define SPT_SUB_PHY 8'h01
`define SPT_SUB_SHARED 8'h02
`define SPT_SUB_VEND_LO 8'hE0
`define SPT_SUB_VEND_HI 8'hFE
`define SPT_SUB_ALL 8'hFF
// Timing
// Clock cycles per millisecond at 40 MHz
`define SPT_TICK_CYC 16'h9C40
`endif

// ==== hw/spt_ms_timer.v ====
`include "spt_consts.vh"
`default_nettype none
// Millisecond down-counter; a zero load leaves it idle
module spt_ms_timer (
  input wire clk, // Clock
  input wire rst, // Sync reset
  input wire tick, // Millisecond tick
  input wire start, // Load and run
  input wire stop, // Halt
  input wire [15:0] loadVal, // Milliseconds to count
  output reg running, // Counting
  output reg expired // One-cycle expiry pulse
);
  reg [15:0] count_q;
  always @(posedge clk) begin
    expired <= 1'b0;
    if (rst) begin
      running <= 1'b0;
      count_q <= 16'h0000;
    end else if (stop) begin
      running <= 1'b0;
    end else if (start) begin
      count_q <= loadVal;
      running <= (loadVal != 16'h0000);
    end else if (running && tick) begin
      if (count_q == 16'h0001) begin
        running <= 1'b0;
        expired <= 1'b1;
      end
      count_q <= count_q - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== tb/spt_port_params_assertions.sv ====
`default_nettype none
module spt_port_params_chk #(parameter NPORT = 2) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic pageWr, // Write
  input wire logic pageRd, // Read
  input wire logic [2:0] pageAddr, // Offset
  input wire logic [7:0] pageWrData, // Write byte
  input wire logic [7:0] subpageCode, // Code
  input wire logic [NPORT-1:0] connRejected, // Retrying
  input wire logic [7:0] pageRdData, // Read byte
  input wire logic pageRdValid, // Read valid
  input wire logic pageWrErr, // Refused
  input wire logic [2:0] subpageClass, // Class
  input wire logic indicatorMeaning, // Shared bit
  input wire logic [NPORT-1:0] nexusLoss // Loss
);
  timeunit 1ns;
  timeprecision 100ps;
  function automatic logic [2:0] cls(input logic [7:0] c);
    if (c >= 8'hE0) return c == 8'hFF ? 3'h5 : 3'h4;
    return c < 8'h03 ? c[2:0] + 3'h1 : 3'h0;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (pageRd |=> pageRdValid)
    else $error("read not answered");
  a_page_code: assert property (pageRd && pageAddr == 3'h0 |=>
    pageRdData[6:0] == 7'h19) else $error("bad page code");
  a_page_length: assert property (pageRd && pageAddr == 3'h1 |=>
    pageRdData == 8'h06) else $error("bad page length");
  a_proto_code: assert property (pageRd && pageAddr == 3'h2 |=>
    pageRdData[3:0] == 4'h6) else $error("bad protocol code");
  a_ind_shared: assert property (pageRd && pageAddr == 3'h2 &&
    !pageWr |=> pageRdData[4] == indicatorMeaning) else $error("ind bit");
  a_spf_refused: assert property (pageWr && pageAddr == 3'h0 &&
    pageWrData[6] |=> pageWrErr) else $error("format write kept");
  a_sub_class: assert property (!rst ##1 $stable(subpageCode) |->
    subpageClass == cls(subpageCode)) else $error("bad subpage class");
  a_loss_cause: assert property (nexusLoss[0] |->
    $past(connRejected[0])) else $error("loss without retry");
  cover property (pageWrErr);
  cover property (nexusLoss[0]);
  cover property (subpageClass == 3'h5);
endmodule
bind spt_port_params spt_port_params_chk #(.NPORT(NPORT)) chk (.clk, .rst,
  .pageWr, .pageRd, .pageAddr, .pageWrData, .subpageCode, .connRejected,
  .pageRdData, .pageRdValid, .pageWrErr, .subpageClass, .indicatorMeaning,
  .nexusLoss);
`default_nettype wire

// ==== tb/spt_init_model.sv ====
`default_nettype none
// Initiator: retries until loss is seen, awaits frames until abort
module spt_init_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic run, // Start traffic
  input wire logic [1:0] nexusLoss, // Loss seen
  input wire logic [1:0] cmdAbort, // Abort seen
  output logic [1:0] connRejected, // Retrying
  output logic [1:0] frameExpect // Awaiting frame
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] lost_q, done_q;
  always @(posedge clk) begin
    if (rst || !run) begin
      lost_q <= 2'h0;
      done_q <= 2'h0;
    end else begin
      lost_q <= lost_q | nexusLoss;
      done_q <= done_q | cmdAbort;
    end
  end
  assign connRejected = {2{run}} & ~lost_q;
  assign frameExpect = {2{run}} & ~done_q;
endmodule
`default_nettype wire

// ==== tb/tb_spt_port_params.sv ====
`default_nettype none
module tb_spt_port_params;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, pageWr = 1'b0, pageRd = 1'b0;
  logic sharedPolicy = 1'b0, run = 1'b0, pageRdValid, pageWrErr;
  logic indicatorMeaning;
  logic [0:0] portSel = 1'h0;
  logic [2:0] pageAddr = 3'h0, subpageClass;
  logic [7:0] pageWrData = 8'h00, subpageCode = 8'h00, pageRdData;
  logic [1:0] connRejected, frameExpect, nexusLoss, cmdAbort;
  int mismatches = 0, n_compared = 0;
  spt_port_params DUT (.clk, .rst, .pageWr, .pageRd, .pageAddr,
    .pageWrData, .portSel, .sharedPolicy, .subpageCode, .connRejected,
    .connAccepted(2'h0), .frameExpect, .frameRcvd(2'h0), .pageRdData,
    .pageRdValid, .pageWrErr, .subpageClass, .indicatorMeaning, .nexusLoss,
    .cmdAbort);
  spt_init_model peer (.clk, .rst, .run, .nexusLoss, .cmdAbort,
    .connRejected, .frameExpect);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic p, input logic [2:0] a, input logic [7:0] d,
      input logic e);
    @(posedge clk);
    pageWr <= 1'b1;
    portSel <= p;
    pageAddr <= a;
    pageWrData <= d;
    @(posedge clk);
    pageWr <= 1'b0;
    #1 chk(pageWrErr, e);
  endtask
  task rd(input logic p, input logic [2:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge clk);
    pageRd <= 1'b1;
    portSel <= p;
    pageAddr <= a;
    @(posedge clk);
    pageRd <= 1'b0;
    #1 chk(pageRdValid, 1'b1);
    chk(pageRdData & m, e);
  endtask
  task t_reset_values;
    rd(1'b0, 3'h0, 8'h7F, 8'h19);
    rd(1'b0, 3'h1, 8'hFF, 8'h06);
    rd(1'b0, 3'h2, 8'h1F, 8'h06);
    rd(1'b1, 3'h4, 8'hFF, 8'h07);
    rd(1'b1, 3'h5, 8'hFF, 8'hD0);
    rd(1'b0, 3'h7, 8'hFF, 8'h00);
  endtask
  task t_refuse;
    wr(1'b0, 3'h0, 8'h59, 1'b1);
    wr(1'b0, 3'h0, 8'h19, 1'b0);
    wr(1'b0, 3'h1, 8'h33, 1'b0);
    rd(1'b0, 3'h1, 8'hFF, 8'h06);
  endtask
  task t_ports;
    wr(1'b0, 3'h4, 8'h00, 1'b0);
    wr(1'b0, 3'h5, 8'h01, 1'b0);
    rd(1'b0, 3'h5, 8'hFF, 8'h01);
    rd(1'b1, 3'h5, 8'hFF, 8'hD0);
    wr(1'b0, 3'h2, 8'h10, 1'b0);
    rd(1'b1, 3'h2, 8'h10, 8'h10);
    chk(indicatorMeaning, 1'b1);
    @(posedge clk);
    sharedPolicy <= 1'b1;
    wr(1'b0, 3'h6, 8'h12, 1'b0);
    rd(1'b1, 3'h6, 8'hFF, 8'h12);
    @(posedge clk);
    sharedPolicy <= 1'b0;
    rd(1'b1, 3'h6, 8'hFF, 8'h00);
  endtask
  task t_subpage;
    logic [7:0] code [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hE0, 8'hFE, 8'hFF};
    logic [2:0] cls [7] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h4, 3'h5};
    foreach (code[i]) begin
      @(posedge clk);
      subpageCode <= code[i];
      repeat (2) @(posedge clk);
      #1 chk(subpageClass, cls[i]);
    end
  endtask
  task t_timers;
    int cnt [4] = '{0, 0, 0, 0};
    wr(1'b1, 3'h4, 8'hFF, 1'b0);
    wr(1'b1, 3'h5, 8'hFF, 1'b0);
    wr(1'b1, 3'h7, 8'h01, 1'b0);
    @(posedge clk);
    run <= 1'b1;
    repeat (82000) begin
      @(posedge clk);
      cnt[0] += nexusLoss[0];
      cnt[1] += nexusLoss[1];
      cnt[2] += cmdAbort[0];
      cnt[3] += cmdAbort[1];
    end
    chk(cnt[0], 16'h0001);
    chk(cnt[1], 16'h0000);
    chk(cnt[2], 16'h0000);
    chk(cnt[3], 16'h0001);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_refuse();
    t_ports();
    t_subpage();
    t_timers();
    test_done();
  end
endmodule
`default_nettype wire
